// file: pkg/raw_pkg.sv
package raw_pkg;
  // Register indices (byte address equals index on this port)
  localparam logic [3:0] ADDR_FLAGS    = 4'h0;
  localparam logic [3:0] ADDR_ALM_SEC  = 4'h2;
  localparam logic [3:0] ADDR_ALM_MIN  = 4'h3;
  localparam logic [3:0] ADDR_ALM_HR   = 4'h4;
  localparam logic [3:0] ADDR_ALM_DATE = 4'h5;
  localparam logic [3:0] ADDR_INT_CTRL = 4'h6;
  localparam logic [3:0] ADDR_WDOG     = 4'h7;
  // event_flags bits
  localparam int FLG_WDF  = 7;
  localparam int FLG_AF   = 6;
  localparam int FLG_PF   = 5;
  localparam int FLG_OSC_STOPPED_FLAG = 4;
  localparam int FLG_CAL  = 2;
  localparam int FLG_W    = 1;
  localparam int FLG_R    = 0;
  // interrupt_control bits
  localparam int IC_WIE = 7;
  localparam int IC_AIE = 6;
  localparam int IC_PFE = 5;
  localparam int IC_HL  = 3;
  localparam int IC_PL  = 2;
  localparam logic [7:0] IC_WMASK = 8'he0 | 8'h0c;
  // watchdog_control bits, plus alarm mask bit
  localparam int WD_STROBE = 7;
  localparam int WD_LOCK   = 6;
  localparam int ALM_MASK  = 7;
  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] IC_RST    = 8'h08;
  localparam logic [7:0] ALM_RST   = 8'h80;
  localparam logic [5:0] WDT_RST   = 6'h00;
  // Timing: 200 ms pulse counted in 32 Hz ticks
  localparam int TICK_HZ       = 32;
  localparam int PULSE_MS      = 200;
  localparam logic [3:0] PULSE_TICKS = 4'((PULSE_MS * TICK_HZ) / 1000);
endpackage

// file: src/raw_irq.sv
`timescale 1ns/100ps
// Notes on behaviour
// [R1] Alarm date, hours, minutes, seconds compared with current time fields.
// [R2] Match sets alarm flag; pin asserts only if alarm enable is 1.
// [R3] Per-field mask: 0 includes the field, 1 excludes it.
// [R4] All masks 1 disables alarm; all 0 needs exact match.
// [R5] Reading flags clears alarm, watchdog, supply-loss flags and idles pin.
// [R6] Host sets freeze bit, writes alarm values, then clears it.
// [R7] Host keeps the seconds mask bit at 0.
// [R8] Watchdog counts down on 32 Hz tick, not while oscillator stopped.
// [R9] Load timeout at power-up; strobe write reloads and restarts counter.
// [R10] Counter reaching 0 sets watchdog flag; interrupt only if enabled.
// [R11] Write lock 1 ignores timeout writes; 0 lets them update.
// [R12] Timeout value zero disables watchdog entirely.
// [R13] Watchdog enable 1 drives pin too; 0 sets flag only.
// [R14] Flags set by timeout, alarm match and supply below threshold.
// [R15] On backup supply, block register access; clock keeps running.
// [R16] Pin active only for a set flag whose enable is 1.
// [R17] Pulse mode holds pin about 200 ms; level mode until flags read.
// [R18] Polarity 1 push-pull high on main power; 0 open drain low.
// [R19] No interrupts while on backup power.
// [R20] Host ignores pin for recall settle time after power-up.
// [R21] Flags read during a pulse ends it at once and clears flags.
// [R22] Flags zero at power-up except oscillator-fail bit; here reset clears that bit too, and only osc_fail_det sets it.
// [R23] Timeout counts in 31.25 ms units, 1 to 63.
// [R24] Freeze bit stops updates; clearing it transfers written values.
// [R25] Alarm evaluated once per seconds update.
module raw_irq
  import raw_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Time base and current time (same clock domain)
  input  wire logic       tick_32hz,
  input  wire logic       sec_update,
  input  wire logic [7:0] cur_sec,
  input  wire logic [7:0] cur_min,
  input  wire logic [7:0] cur_hr,
  input  wire logic [7:0] cur_date,
  input  wire logic       osc_running,
  input  wire logic       osc_fail_det,
  // Supply monitor pin (asynchronous)
  input  wire logic       supply_low,
  // Interrupt pin and freeze status
  output logic            int_out,
  output logic            int_oe,
  output logic            freeze
);

  logic [1:0] sl_sync_reg;
  logic       on_backup;
  logic       on_backup_d_reg;
  logic       wr_ok;
  logic       rd_ok;
  logic       flags_rd;
  logic [7:0] flags_reg;
  logic [7:0] ic_reg;
  logic [7:0] alm_reg [4];
  logic [7:0] alm_act_reg [4];
  logic [7:0] cur_f [4];
  logic [3:0] fld_hit;
  logic       alarm_hit;
  logic       wd_lock_reg;
  logic [5:0] wdt_reg;
  logic [5:0] wd_cnt_reg;
  logic       wd_load_reg;
  logic       wd_expire;
  logic       irq_req;
  logic       pin_act_reg;
  logic [3:0] pulse_cnt_reg;

  // Supply level is asynchronous to clk
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sl_sync_reg <= 2'b00;
    end else begin
      sl_sync_reg <= {sl_sync_reg[0], supply_low};
    end
  end
  assign on_backup = sl_sync_reg[1];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      on_backup_d_reg <= 1'b0;
    end else begin
      on_backup_d_reg <= on_backup;
    end
  end

  // Register access refused on backup supply
  assign wr_ok    = wr && !on_backup; // R15
  assign rd_ok    = rd && !on_backup; // R15
  assign flags_rd = rd_ok && (addr == ADDR_FLAGS);
  assign freeze   = flags_reg[FLG_W];

  // Alarm fields: index 0 sec, 1 min, 2 hr, 3 date
  assign cur_f[0] = cur_sec;
  assign cur_f[1] = cur_min;
  assign cur_f[2] = cur_hr;
  assign cur_f[3] = cur_date;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_alm
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          alm_reg[g] <= ALM_RST;
        end else if (wr_ok && addr == ADDR_ALM_SEC + 4'(g)) begin
          alm_reg[g] <= wdata;
        end
      end
      // Staged values take effect when freeze drops
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          alm_act_reg[g] <= ALM_RST;
        end else if (!flags_reg[FLG_W]) begin
          alm_act_reg[g] <= alm_reg[g]; // R24 R6
        end
      end
      assign fld_hit[g] = alm_act_reg[g][ALM_MASK] || // R3
                          (alm_act_reg[g][6:0] == cur_f[g][6:0]); // R1
    end
  endgenerate

  // All-masked never matches; R7 keeps seconds in play for at most one hit per minute
  assign alarm_hit = sec_update && (&fld_hit) && // R25 R1
                     !(alm_act_reg[0][ALM_MASK] && alm_act_reg[1][ALM_MASK] &&
                       alm_act_reg[2][ALM_MASK] && alm_act_reg[3][ALM_MASK]); // R4

  // Interrupt control register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ic_reg <= IC_RST;
    end else if (wr_ok && addr == ADDR_INT_CTRL) begin
      ic_reg <= wdata & IC_WMASK;
    end
  end

  // Watchdog control; lock reflects the previous write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wd_lock_reg <= 1'b0;
      wdt_reg     <= WDT_RST;
    end else if (wr_ok && addr == ADDR_WDOG) begin
      wd_lock_reg <= wdata[WD_LOCK];
      if (!wd_lock_reg) begin
        wdt_reg <= wdata[5:0]; // R11
      end
    end
  end

  // Power-up load request, then strobe reloads
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wd_load_reg <= 1'b1;
    end else begin
      wd_load_reg <= wr_ok && addr == ADDR_WDOG && wdata[WD_STROBE]; // R9
    end
  end

  assign wd_expire = tick_32hz && osc_running && (wdt_reg != 6'h00) && // R8 R12
                     !wd_load_reg && (wd_cnt_reg == 6'h01); // R10 R23

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wd_cnt_reg <= WDT_RST;
    end else if (wd_load_reg) begin
      wd_cnt_reg <= wdt_reg; // R9
    end else if (tick_32hz && osc_running && wd_cnt_reg != 6'h00) begin
      wd_cnt_reg <= wd_cnt_reg - 6'h01; // R8 R23
    end
  end

  // Flags: set wins over read-clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_reg <= FLAGS_RST; // R22
    end else begin
      if (flags_rd) begin
        flags_reg[FLG_WDF] <= 1'b0; // R5
        flags_reg[FLG_AF]  <= 1'b0; // R5
        flags_reg[FLG_PF]  <= 1'b0; // R5
      end
      if (wr_ok && addr == ADDR_FLAGS) begin
        flags_reg[FLG_CAL] <= wdata[FLG_CAL];
        flags_reg[FLG_W]   <= wdata[FLG_W];
        flags_reg[FLG_R]   <= wdata[FLG_R];
        if (flags_reg[FLG_W] && !wdata[FLG_OSC_STOPPED_FLAG]) begin
          flags_reg[FLG_OSC_STOPPED_FLAG] <= 1'b0;
        end
      end
      if (osc_fail_det) begin
        flags_reg[FLG_OSC_STOPPED_FLAG] <= 1'b1;
      end
      if (wd_expire) begin
        flags_reg[FLG_WDF] <= 1'b1; // R14 R10
      end
      if (alarm_hit) begin
        flags_reg[FLG_AF] <= 1'b1; // R14 R2
      end
      if (on_backup && !on_backup_d_reg) begin
        flags_reg[FLG_PF] <= 1'b1; // R14
      end
    end
  end

  // Enabled watchdog and alarm events request the pin; the supply-loss term is always blocked by !on_backup
  assign irq_req = !on_backup && // R19
                   ((wd_expire && ic_reg[IC_WIE]) || // R13 R16
                    (alarm_hit && ic_reg[IC_AIE]) || // R2 R16
                    (on_backup && !on_backup_d_reg && ic_reg[IC_PFE])); // R16

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_act_reg   <= 1'b0;
      pulse_cnt_reg <= 4'h0;
    end else if (irq_req) begin
      pin_act_reg   <= 1'b1;
      pulse_cnt_reg <= PULSE_TICKS;
    end else if (flags_rd) begin
      pin_act_reg   <= 1'b0; // R5 R21
      pulse_cnt_reg <= 4'h0;
    end else if (pin_act_reg && ic_reg[IC_PL] && tick_32hz) begin
      pulse_cnt_reg <= pulse_cnt_reg - 4'h1; // R17
      if (pulse_cnt_reg == 4'h1) begin
        pin_act_reg <= 1'b0; // R17
      end
    end
  end

  // Active high drives both levels on main power; active low is open drain
  always_comb begin
    if (ic_reg[IC_HL]) begin
      int_out = pin_act_reg && !on_backup; // R18 R19
      int_oe  = !on_backup; // R18
    end else begin
      int_out = 1'b0;
      int_oe  = pin_act_reg && !on_backup; // R18 R19
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd_ok) begin
      unique case (addr)
        ADDR_FLAGS:    rdata <= {flags_reg[7:4], 1'b0, flags_reg[2:0]};
        ADDR_ALM_SEC:  rdata <= alm_reg[0];
        ADDR_ALM_MIN:  rdata <= alm_reg[1];
        ADDR_ALM_HR:   rdata <= alm_reg[2];
        ADDR_ALM_DATE: rdata <= alm_reg[3];
        ADDR_INT_CTRL: rdata <= ic_reg;
        ADDR_WDOG:     rdata <= {1'b0, wd_lock_reg, wdt_reg};
        default:       rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Assertions
  wdf_set_a: assert property (@(posedge clk) disable iff (!nrst)
    wd_expire |=> flags_reg[FLG_WDF]) else $error("watchdog flag not set"); // R10
  wd_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (wdt_reg == 6'h00) |-> !wd_expire) else $error("disabled watchdog fired"); // R12
  flag_clr_a: assert property (@(posedge clk) disable iff (!nrst)
    (flags_rd && !wd_expire && !alarm_hit && !(on_backup && !on_backup_d_reg))
      |=> !flags_reg[FLG_AF] && !flags_reg[FLG_WDF] && !flags_reg[FLG_PF]) else $error("flags kept"); // R5
  pin_rd_a: assert property (@(posedge clk) disable iff (!nrst)
    (flags_rd && !irq_req) |=> !pin_act_reg) else $error("pin active after read"); // R21
  alm_off_a: assert property (@(posedge clk) disable iff (!nrst)
    (alm_act_reg[0][7] && alm_act_reg[1][7] && alm_act_reg[2][7] && alm_act_reg[3][7])
      |-> !alarm_hit) else $error("masked alarm hit"); // R4
  bkp_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    on_backup |-> !(int_oe && !ic_reg[IC_HL]) && !int_out) else $error("pin on backup"); // R19
  no_osc_a: assert property (@(posedge clk) disable iff (!nrst)
    (!osc_running && !wd_load_reg) |=> $stable(wd_cnt_reg)) else $error("counted without osc"); // R8
  lock_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_ok && addr == ADDR_WDOG && wd_lock_reg) |=> $stable(wdt_reg)) else $error("locked write"); // R11
  irq_en_a: assert property (@(posedge clk) disable iff (!nrst)
    (alarm_hit && !ic_reg[IC_AIE] && !pin_act_reg && !wd_expire && on_backup_d_reg == on_backup)
      |=> !pin_act_reg) else $error("disabled source drove pin"); // R16

  // Watchdog: strobe, reload, count down, rest at zero
  sequence wd_strobe_s;
    wr_ok && addr == ADDR_WDOG && wdata[WD_STROBE];
  endsequence

  sequence wd_reload_s;
    wd_load_reg ##1 (wd_cnt_reg == $past(wdt_reg));
  endsequence

  wd_reload_a: assert property (@(posedge clk) disable iff (!nrst) // R9
    wd_strobe_s |=> wd_reload_s)
    else $error("watchdog not reloaded");

  wd_count_a: assert property (@(posedge clk) disable iff (!nrst) // R8 R23
    (tick_32hz && osc_running && !wd_load_reg && wd_cnt_reg != 6'h00)
      |=> wd_cnt_reg == $past(wd_cnt_reg) - 6'h01)
    else $error("watchdog step wrong");

  wd_stop_a: assert property (@(posedge clk) disable iff (!nrst) // R12
    (wd_cnt_reg == 6'h00 && !wd_load_reg) |=> wd_cnt_reg == 6'h00)
    else $error("watchdog left zero");

  // Disabled watchdog source still records its flag
  wd_flag_only_a: assert property (@(posedge clk) disable iff (!nrst) // R13
    (wd_expire && !ic_reg[IC_WIE] && !(alarm_hit && ic_reg[IC_AIE]) &&
     !pin_act_reg && on_backup == on_backup_d_reg)
      |=> !pin_act_reg && flags_reg[FLG_WDF])
    else $error("watchdog flag only broken");

  // Alarm: exact match, unmasked mismatch, flag, freeze
  sequence alarm_exact_s;
    sec_update &&
    !alm_act_reg[0][ALM_MASK] && !alm_act_reg[1][ALM_MASK] &&
    !alm_act_reg[2][ALM_MASK] && !alm_act_reg[3][ALM_MASK] &&
    alm_act_reg[0][6:0] == cur_sec[6:0] && alm_act_reg[1][6:0] == cur_min[6:0] &&
    alm_act_reg[2][6:0] == cur_hr[6:0] && alm_act_reg[3][6:0] == cur_date[6:0];
  endsequence

  alm_exact_a: assert property (@(posedge clk) disable iff (!nrst) // R4 R1
    alarm_exact_s |-> alarm_hit)
    else $error("exact alarm missed");

  alm_miss_a: assert property (@(posedge clk) disable iff (!nrst) // R3
    (!alm_act_reg[0][ALM_MASK] && alm_act_reg[0][6:0] != cur_sec[6:0]) |-> !alarm_hit)
    else $error("unmasked field ignored");

  af_set_a: assert property (@(posedge clk) disable iff (!nrst) // R2 R14
    alarm_hit |=> flags_reg[FLG_AF])
    else $error("alarm flag not set");

  // Staged alarm values must not leak while frozen
  frz_hold_a: assert property (@(posedge clk) disable iff (!nrst) // R24
    flags_reg[FLG_W] |=> $stable(alm_act_reg[0]) && $stable(alm_act_reg[1]) &&
                         $stable(alm_act_reg[2]) && $stable(alm_act_reg[3]))
    else $error("alarm changed while frozen");

  // Supply monitor and backup refusal
  pf_set_a: assert property (@(posedge clk) disable iff (!nrst) // R14
    (on_backup && !on_backup_d_reg) |=> flags_reg[FLG_PF])
    else $error("supply flag not set");

  bkp_rd_a: assert property (@(posedge clk) disable iff (!nrst) // R15
    (rd && on_backup) |=> rdata == 8'h00)
    else $error("read served on backup");

  bkp_wr_a: assert property (@(posedge clk) disable iff (!nrst) // R15
    (wr && on_backup) |=> $stable(ic_reg))
    else $error("write taken on backup");

  // Pin driver: start, hold, pulse end, read-back
  pin_set_a: assert property (@(posedge clk) disable iff (!nrst) // R16 R17
    irq_req |=> pin_act_reg && pulse_cnt_reg == PULSE_TICKS)
    else $error("pin not started");

  pin_hold_a: assert property (@(posedge clk) disable iff (!nrst) // R17
    (pin_act_reg && !ic_reg[IC_PL] && !flags_rd) |=> pin_act_reg)
    else $error("level pin dropped");

  sequence pulse_end_s;
    pin_act_reg && ic_reg[IC_PL] && tick_32hz && pulse_cnt_reg == 4'h1 && !irq_req;
  endsequence

  pulse_end_a: assert property (@(posedge clk) disable iff (!nrst) // R17
    pulse_end_s |=> !pin_act_reg)
    else $error("pulse overran");

  rd_flags_a: assert property (@(posedge clk) disable iff (!nrst) // R5
    flags_rd |=> rdata[7:4] == $past(flags_reg[7:4]))
    else $error("flags read data wrong");

endmodule

// file: testbench/raw_host_model.sv
`timescale 1ns/100ps
module raw_host_model #(
  parameter int SETTLE_CYC = 8
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Interrupt pin as seen by the host
  input  wire logic int_out,
  input  wire logic int_oe,
  input  wire logic active_high,
  output logic      pin,
  output logic      irq_seen
);
  logic [3:0] settle_reg;
  // Released line rests inactive: pull-up in open-drain mode
  assign pin = int_oe ? int_out : !active_high;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      settle_reg <= 4'h0;
    else if (settle_reg != 4'(SETTLE_CYC))
      settle_reg <= settle_reg + 4'h1;
  end
  // Pin activity before recall settles is not trusted
  assign irq_seen = (settle_reg == 4'(SETTLE_CYC)) && (pin == active_high);
endmodule

// file: testbench/test_rtc_alarm_watchdog_irq.sv
`timescale 1ns/100ps
module test_rtc_alarm_watchdog_irq;
  import raw_pkg::*;
  logic       clk, nrst, wr, rd, sec_update, osc_running, supply_low, hi_mode;
  logic       tick_32hz, int_out, int_oe, freeze, pin, irq_seen;
  logic [3:0] addr, div_reg;
  logic [7:0] wdata, rdata, cur_sec, v;
  int         bad_count, check_count;

  raw_irq dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .tick_32hz(tick_32hz), .sec_update(sec_update), .cur_sec(cur_sec), .cur_min(8'h00), .cur_hr(8'h00),
    .cur_date(8'h01), .osc_running(osc_running), .osc_fail_det(1'b0), .supply_low(supply_low),
    .int_out(int_out), .int_oe(int_oe), .freeze(freeze));
  raw_host_model host (.clk(clk), .nrst(nrst), .int_out(int_out), .int_oe(int_oe), .active_high(hi_mode),
    .pin(pin), .irq_seen(irq_seen));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Tick shrunk to one pulse every 10 clocks to keep the run short
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      div_reg <= 4'h0;
    else
      div_reg <= (div_reg == 4'h9) ? 4'h0 : div_reg + 4'h1;
  end
  assign tick_32hz = (div_reg == 4'h9);

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_ticks(input int n);
    repeat (10 * n) @(posedge clk);
    #1;
  endtask
  task automatic second(input logic [7:0] s);
    @(posedge clk);
    cur_sec    <= s;
    sec_update <= 1'b1;
    @(posedge clk);
    sec_update <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic pin_is(input logic act);
    check({6'h00, int_oe, int_out}, hi_mode ? {6'h00, 1'b1, act} : {6'h00, act, 1'b0});
    check({7'h00, irq_seen}, {7'h00, act});
  endtask

  task automatic t_reset();
    rd_reg(ADDR_FLAGS);
    check(v, FLAGS_RST);
    rd_reg(ADDR_INT_CTRL);
    check(v, IC_RST);
    pin_is(1'b0);
    $display("test reset done");
  endtask
  task automatic t_watchdog();
    wr_reg(ADDR_INT_CTRL, 8'h88);
    wr_reg(ADDR_WDOG, 8'h83);
    wait_ticks(2);
    pin_is(1'b0);
    wait_ticks(2);
    pin_is(1'b1);
    rd_reg(ADDR_FLAGS);
    check(v, 8'h80);
    pin_is(1'b0);
    wr_reg(ADDR_WDOG, 8'h43);
    wr_reg(ADDR_WDOG, 8'h45);
    rd_reg(ADDR_WDOG);
    check(v & 8'h3f, 8'h03);
    wr_reg(ADDR_WDOG, 8'hc0);
    osc_running <= 1'b0;
    wait_ticks(5);
    pin_is(1'b0);
    @(posedge clk);
    osc_running <= 1'b1;
    wait_ticks(4);
    pin_is(1'b1);
    rd_reg(ADDR_FLAGS);
    wr_reg(ADDR_INT_CTRL, 8'h08);
    wr_reg(ADDR_WDOG, 8'h83);
    wait_ticks(4);
    pin_is(1'b0);
    rd_reg(ADDR_FLAGS);
    check(v, 8'h80);
    wr_reg(ADDR_WDOG, 8'h80);
    wait_ticks(4);
    rd_reg(ADDR_FLAGS);
    check(v, 8'h00);
    $display("test watchdog done");
  endtask
  task automatic t_alarm(input logic [7:0] ic);
    hi_mode <= ic[IC_HL];
    wr_reg(ADDR_INT_CTRL, ic);
    wr_reg(ADDR_FLAGS, 8'h02);
    #1;
    check({7'h00, freeze}, 8'h01);
    wr_reg(ADDR_ALM_SEC, 8'h15);
    wr_reg(ADDR_ALM_MIN, 8'h80);
    wr_reg(ADDR_ALM_HR, 8'h80);
    wr_reg(ADDR_ALM_DATE, 8'h80);
    wr_reg(ADDR_FLAGS, 8'h00);
    second(8'h14);
    pin_is(1'b0);
    second(8'h15);
    pin_is(1'b1);
    wait_ticks(4);
    pin_is(1'b1);
    wait_ticks(4);
    pin_is(!ic[IC_PL]);
    rd_reg(ADDR_FLAGS);
    check(v, 8'h40);
    pin_is(1'b0);
    second(8'h15);
    pin_is(1'b1);
    rd_reg(ADDR_FLAGS);
    pin_is(1'b0);
    check(v, 8'h40);
    wr_reg(ADDR_FLAGS, 8'h02);
    wr_reg(ADDR_ALM_SEC, 8'h95);
    wr_reg(ADDR_FLAGS, 8'h00);
    second(8'h15);
    rd_reg(ADDR_FLAGS);
    check(v, 8'h00);
    wr_reg(ADDR_INT_CTRL, ic & 8'hbf);
    wr_reg(ADDR_FLAGS, 8'h02);
    wr_reg(ADDR_ALM_SEC, 8'h15);
    wr_reg(ADDR_ALM_MIN, 8'h00);
    wr_reg(ADDR_ALM_HR, 8'h00);
    wr_reg(ADDR_ALM_DATE, 8'h01);
    wr_reg(ADDR_FLAGS, 8'h00);
    second(8'h15);
    pin_is(1'b0);
    rd_reg(ADDR_FLAGS);
    check(v, 8'h40);
    $display("test alarm done");
  endtask
  task automatic t_supply();
    hi_mode <= 1'b1;
    wr_reg(ADDR_INT_CTRL, 8'h28);
    supply_low <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check({6'h00, int_oe, int_out}, 8'h00);
    check({7'h00, irq_seen}, 8'h00);
    wr_reg(ADDR_INT_CTRL, 8'h00);
    rd_reg(ADDR_FLAGS);
    check(v, 8'h00);
    @(posedge clk);
    supply_low <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(ADDR_FLAGS);
    check(v, 8'h20);
    pin_is(1'b0);
    rd_reg(ADDR_INT_CTRL);
    check(v, 8'h28);
    $display("test supply done");
  endtask

  initial begin
    nrst        = 1'b0;
    wr          = 1'b0;
    rd          = 1'b0;
    addr        = 4'h0;
    wdata       = 8'h00;
    sec_update  = 1'b0;
    cur_sec     = 8'h00;
    osc_running = 1'b1;
    supply_low  = 1'b0;
    hi_mode     = 1'b1;
    bad_count   = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_watchdog();
    t_alarm(8'h4c);
    t_alarm(8'h40);
    t_supply();
    final_report();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    final_report();
  end
endmodule
